// ### core/smon_pkg.sv
// What this block does
// R1: selectable die overtemperature trip level, four steps
// R2: temperature comparators always on, never gated
// R3: die over trip sets flag, pulls fault
// R4: supply comparators off at reset, enabled by config
// R5: reference-input comparator needs internal enable bit
// R6: one sticky status bit per monitored supply
// R7: reference-output fault sets its own error bit
// R8: analog flags sticky, write-one clear, fault persists
// R9: fault pin active low open drain
// R10: every readback carries inverted fault pin level
// R11: unrefreshed/reset/slew flags excluded; others reach pin, seven maskable, four fixed
// R12: interface, parity, crc always drive pin; clock count drives pin unless quiet bit set
// R13: output and temperature faults maskable onto pin
// R14: converter power and supply faults unmaskable
// R15: quiet bit drops clock count errors from pin
// R16: status shows digital, analog, watchdog summaries
// R17: summaries non-sticky ORs, slew flag excluded
// R18: host treats line wired-AND, reads each status
package smon_pkg;
   localparam int unsigned DW = 16;
   localparam int unsigned AW = 4;
   // register offsets
   localparam logic [3:0] OFS_CFG_A = 4'h0;
   localparam logic [3:0] OFS_CFG_B = 4'h1;
   localparam logic [3:0] OFS_CONV = 4'h2;
   localparam logic [3:0] OFS_DMASK = 4'h3;
   localparam logic [3:0] OFS_DIG = 4'h4;
   localparam logic [3:0] OFS_ANA = 4'h5;
   localparam logic [3:0] OFS_STAT = 4'h6;
   localparam logic [3:0] OFS_IRQ = 4'h7;
   localparam logic [3:0] OFS_IMASK = 4'h8;
   localparam logic [3:0] OFS_AMASK = 4'h9;
   // field positions
   localparam int unsigned CFGA_QUIET = 3;
   localparam int unsigned CONV_INT_EN = 0;
   localparam int unsigned CFGB_REFI = 0;
   localparam int unsigned CFGB_REFO = 1;
   localparam int unsigned CFGB_AVCC = 2;
   localparam int unsigned CFGB_LDO = 3;
   localparam int unsigned ST_DIG = 0;
   localparam int unsigned ST_ANA = 1;
   localparam int unsigned ST_WDT = 2;
   localparam int unsigned RD_FAULT = 15;
   localparam int unsigned IRQ_DIG = 0;
   localparam int unsigned IRQ_ANA = 1;
   localparam int unsigned IRQ_PIN = 2;
   // digital flag bits
   localparam int unsigned D_WDT = 4;
   localparam int unsigned D_UNREF = 1;
   localparam int unsigned D_SCLK = 10;
   localparam int unsigned D_SLEW = 13;
   // analog flag bits
   localparam int unsigned A_TDC = 5;
   localparam int unsigned A_TMAIN = 6;
   localparam int unsigned A_REFI = 8;
   localparam int unsigned A_AVCC = 9;
   // source groups
   localparam logic [13:0] DIG_MASKABLE = 14'h1AD1;
   localparam logic [13:0] DIG_FIXED = 14'h0528;
   localparam logic [13:0] DIG_STICKY = 14'h1FFD;
   localparam logic [10:0] ANA_MASKABLE = 11'h07B;
   localparam logic [10:0] ANA_FIXED = 11'h784;
   // reset values
   localparam logic [13:0] DIG_RST = 14'h0004;
   localparam logic [14:0] CFG_RST = 15'h0000;
   localparam logic [1:0] TRIP_RST = 2'h0;

   typedef struct packed {
      logic slew_busy;
      logic serial_crc;
      logic slip;
      logic sclk_count;
      logic invalid_access;
      logic cal_crc;
      logic inverse_check;
      logic latch_mon;
      logic wire3_parity;
      logic watchdog;
      logic wire3;
      logic reset_seen;
      logic cal_unrefreshed;
      logic osc_stop;
   } smon_dig_s;

   typedef struct packed {
      logic regulator_node;
      logic internal_supply_node;
      logic ref_input_node;
      logic ref_output_error;
      logic temp_main;
      logic temp_conv;
      logic vout_short;
      logic iout_open;
      logic conv_power;
      logic conv_short;
      logic overvoltage;
   } smon_ana_s;

   typedef struct packed {
      logic [14:0] cfg_a;
      logic [14:0] cfg_b;
      logic [14:0] conv;
      logic [13:0] dmask;
      logic [10:0] amask;
      logic [2:0] imask;
      logic [13:0] dig;
      logic [10:0] ana;
      logic [2:0] irq;
      logic [11:0] sync1;
      logic [11:0] sync2;
      logic [15:0] rdata;
      logic fault_oen;
      logic pin_lvl;
      logic irq_out;
      logic [1:0] trip;
      logic [3:0] cmp_en;
      logic ref_buf_en;
   } smon_state_s;
endpackage

// ### core/smon_core.sv
`timescale 1ns/1ps
module smon_core
   import smon_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DW-1:0] rdata_o,
   input wire smon_dig_s dig_fault_i,
   input wire smon_ana_s ana_cond_i,
   output logic [1:0] trip_level_o,
   output logic [3:0] cmp_en_o,
   output logic ref_buf_en_o,
   input wire logic fault_n_i,
   output logic fault_n_o,
   output logic fault_n_oen_o,
   output logic irq_o
);
   smon_state_s s_reg;
   smon_state_s s_next;
   logic [10:0] ana_now;
   logic [10:0] ana_gate;
   logic [13:0] dig_now;
   logic [13:0] dig_w1c;
   logic [10:0] ana_w1c;
   logic [13:0] dig_map;
   logic [10:0] ana_map;
   logic fault_act;
   logic dig_sum;
   logic ana_sum;
   logic pin_low;
   logic [14:0] rd_val;

   always_comb begin
      s_next = s_reg;
      pin_low = ~s_reg.sync2[11];
      // supply comparators gated by config; temps never gated
      ana_gate = 11'h7FF;
      ana_gate[7] = s_reg.cfg_b[CFGB_REFO]; // [R4] [R7]
      ana_gate[8] = s_reg.cfg_b[CFGB_REFI] & s_reg.conv[CONV_INT_EN]; // [R5]
      ana_gate[9] = s_reg.cfg_b[CFGB_AVCC]; // [R4]
      ana_gate[10] = s_reg.cfg_b[CFGB_LDO]; // [R4]
      ana_now = s_reg.sync2[10:0] & ana_gate; // [R2] [R6]
      dig_now = dig_fault_i;
      dig_w1c = '0;
      ana_w1c = '0;
      if (wr_i && addr_i == OFS_DIG) begin
         dig_w1c = wdata_i[13:0];
      end
      if (wr_i && addr_i == OFS_ANA) begin
         ana_w1c = wdata_i[10:0];
      end
      // sticky flags: a live condition wins over the clear
      s_next.ana = (s_reg.ana & ~ana_w1c) | ana_now; // [R3] [R8]
      s_next.dig = ((s_reg.dig & ~dig_w1c) | dig_now) & DIG_STICKY;
      s_next.dig[D_UNREF] = dig_now[D_UNREF];
      s_next.dig[D_SLEW] = dig_now[D_SLEW];
      // pin mapping
      dig_map = (s_reg.dig & DIG_MASKABLE & ~s_reg.dmask) // [R11]
         | (s_reg.dig & DIG_FIXED); // [R12]
      dig_map[D_SCLK] = s_reg.dig[D_SCLK] & ~s_reg.cfg_a[CFGA_QUIET]; // [R15]
      ana_map = (s_reg.ana & ANA_MASKABLE & ~s_reg.amask) // [R13]
         | (s_reg.ana & ANA_FIXED); // [R14]
      fault_act = |dig_map | |ana_map;
      s_next.fault_oen = ~fault_act; // [R9]
      s_next.pin_lvl = 1'b0;
      dig_sum = |(s_reg.dig & ~(14'h1 << D_SLEW)); // [R17]
      ana_sum = |s_reg.ana; // [R17]
      s_next.sync1 = {fault_n_i, ana_cond_i};
      s_next.sync2 = s_reg.sync1;
      if (wr_i) begin
         unique case (addr_i)
            OFS_CFG_A: s_next.cfg_a = wdata_i[14:0];
            OFS_CFG_B: s_next.cfg_b = wdata_i[14:0];
            OFS_CONV: s_next.conv = wdata_i[14:0];
            OFS_DMASK: s_next.dmask = wdata_i[13:0];
            OFS_AMASK: s_next.amask = wdata_i[10:0];
            OFS_IMASK: s_next.imask = wdata_i[2:0];
            default: ;
         endcase
      end
      s_next.trip = s_next.cfg_a[1:0]; // [R1]
      s_next.cmp_en = s_next.cfg_b[3:0]; // [R4]
      s_next.ref_buf_en = s_next.conv[CONV_INT_EN]; // [R5]
      rd_val = '0;
      unique case (addr_i)
         OFS_CFG_A: rd_val = s_reg.cfg_a;
         OFS_CFG_B: rd_val = s_reg.cfg_b;
         OFS_CONV: rd_val = s_reg.conv;
         OFS_DMASK: rd_val = {1'b0, s_reg.dmask};
         OFS_AMASK: rd_val = {4'h0, s_reg.amask};
         OFS_DIG: rd_val = {1'b0, s_reg.dig};
         OFS_ANA: rd_val = {4'h0, s_reg.ana};
         OFS_STAT: rd_val = {12'h000, s_reg.dig[D_WDT], ana_sum, dig_sum}; // [R16]
         OFS_IRQ: rd_val = {12'h000, s_reg.irq};
         OFS_IMASK: rd_val = {12'h000, s_reg.imask};
         default: rd_val = '0;
      endcase
      s_next.rdata = rd_i ? {pin_low, rd_val} : '0; // [R10]
      // read-to-clear events, set wins
      if (rd_i && addr_i == OFS_IRQ) begin
         s_next.irq = '0;
      end
      s_next.irq[IRQ_DIG] = s_next.irq[IRQ_DIG] | |(s_next.dig & ~s_reg.dig);
      s_next.irq[IRQ_ANA] = s_next.irq[IRQ_ANA] | |(s_next.ana & ~s_reg.ana);
      s_next.irq[IRQ_PIN] = s_next.irq[IRQ_PIN] | (fault_act & s_reg.fault_oen);
      s_next.irq_out = |(s_next.irq & s_next.imask);
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_reg <= '0;
         s_reg.dig <= DIG_RST;
         s_reg.cfg_a <= CFG_RST;
         s_reg.cfg_b <= CFG_RST;
         s_reg.trip <= TRIP_RST;
         s_reg.fault_oen <= 1'b1;
         s_reg.sync1 <= 12'h800;
         s_reg.sync2 <= 12'h800;
      end else if (ce_i) begin
         s_reg <= s_next;
      end
   end

   assign rdata_o = s_reg.rdata;
   assign trip_level_o = s_reg.trip;
   assign cmp_en_o = s_reg.cmp_en;
   assign ref_buf_en_o = s_reg.ref_buf_en;
   assign fault_n_o = s_reg.pin_lvl;
   assign fault_n_oen_o = s_reg.fault_oen;
   assign irq_o = s_reg.irq_out;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);

   trip_select_a: assert property ( // [R1]
      ce_i && wr_i && addr_i == OFS_CFG_A |=> trip_level_o == $past(wdata_i[1:0]))
      else $error("trip level not taken from config write");

   temp_sticky_a: assert property ( // [R3]
      ce_i && s_reg.sync2[A_TMAIN] |=> s_reg.ana[A_TMAIN])
      else $error("main die temperature flag not set");

   supply_off_a: assert property ( // [R4]
      ce_i && !s_reg.cfg_b[CFGB_AVCC] && !s_reg.ana[A_AVCC] |=> !s_reg.ana[A_AVCC])
      else $error("supply flag set while comparator disabled");

   ref_input_node_gate_a: assert property ( // [R5]
      ce_i && !s_reg.conv[CONV_INT_EN] && !s_reg.ana[A_REFI] |=> !s_reg.ana[A_REFI])
      else $error("reference input flag set without internal enable");

   w1c_hold_a: assert property ( // [R8]
      ce_i && wr_i && addr_i == OFS_ANA && wdata_i[A_TDC] && s_reg.sync2[A_TDC]
      |=> s_reg.ana[A_TDC])
      else $error("active analog fault cleared by write");

   temp_pin_a: assert property ( // [R13]
      ce_i && s_reg.ana[A_TMAIN] && !s_reg.amask[A_TMAIN] |=> !fault_n_oen_o)
      else $error("unmasked temperature fault did not pull pin");

   pin_mirror_a: assert property ( // [R10]
      ce_i && rd_i |=> rdata_o[RD_FAULT] == !$past(s_reg.sync2[11]))
      else $error("fault status bit does not mirror pin");

   excluded_a: assert property ( // [R11]
      ce_i && (s_reg.dig & ~14'h0006) == '0 && s_reg.ana == '0 |=> fault_n_oen_o)
      else $error("excluded digital flag drove fault pin");

   quiet_a: assert property ( // [R15]
      ce_i && s_reg.dig == (14'h1 << D_SCLK) && s_reg.ana == '0
      && s_reg.cfg_a[CFGA_QUIET] |=> fault_n_oen_o)
      else $error("clock count error drove pin while quiet");

   summary_a: assert property ( // [R17]
      ce_i && rd_i && addr_i == OFS_STAT
      |=> rdata_o[ST_DIG] == |($past(s_reg.dig) & ~(14'h1 << D_SLEW)))
      else $error("digital summary wrong");
endmodule

// ### tb/smon_fault_host.sv
`timescale 1ns/1ps
module smon_fault_host (
   input wire logic fault_n_i,
   input wire logic fault_n_oen_i,
   input wire logic other_pull_i,
   output logic line_o
);
   // shared pull-up, any party may pull low
   assign line_o = ((!fault_n_oen_i && !fault_n_i) || other_pull_i) ? 1'b0 : 1'b1;
endmodule

// ### tb/smon_core_tb.sv
`timescale 1ns/1ps
module smon_core_tb;
   import smon_pkg::*;
   logic clk_sys_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, other = 0;
   logic [AW-1:0] addr_i = '0;
   logic [DW-1:0] wdata_i = '0, rdata_o;
   smon_dig_s dg = '0;
   smon_ana_s an = '0;
   logic [1:0] trip;
   logic [3:0] cmp;
   logic rbuf, fo, foen, irq, line;
   int err_count = 0, n_compared = 0, cycles = 0;
   smon_core u_smon_core (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .dig_fault_i(dg), .ana_cond_i(an), .trip_level_o(trip), .cmp_en_o(cmp),
      .ref_buf_en_o(rbuf), .fault_n_i(line), .fault_n_o(fo), .fault_n_oen_o(foen),
      .irq_o(irq));
   smon_fault_host u_smon_fault_host (.fault_n_i(fo), .fault_n_oen_i(foen),
      .other_pull_i(other), .line_o(line));
   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (err_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   task automatic rdc(input string n, input logic [3:0] a, input logic [15:0] e);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      chk(n, e, rdata_o);
   endtask
   task automatic t_reset();
      rdc("dig", OFS_DIG, 16'h0004);
      chk("oen", 16'h1, {15'h0, foen});
      wr(OFS_DIG, 16'h0004);
      rdc("dig", OFS_DIG, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CFG_A, 16'(i));
         cyc(1);
         chk("trip", 16'(i), {14'h0, trip});
      end
   endtask
   task automatic t_temp();
      an.temp_main <= 1'b1;
      cyc(6);
      chk("oen", 16'h0, {15'h0, foen});
      chk("drv", 16'h0, {15'h0, fo});
      chk("irq", 16'h0, {15'h0, irq});
      wr(OFS_IMASK, 16'h0007);
      cyc(2);
      chk("irq", 16'h1, {15'h0, irq});
      rdc("irqst", OFS_IRQ, 16'h8006);
      cyc(2);
      chk("irq", 16'h0, {15'h0, irq});
      wr(OFS_IMASK, 16'h0000);
      rdc("ana", OFS_ANA, 16'h8040);
      rdc("stat", OFS_STAT, 16'h8002);
      wr(OFS_ANA, 16'h0040);
      rdc("ana", OFS_ANA, 16'h8040);
      an.temp_main <= 1'b0;
      cyc(4);
      wr(OFS_ANA, 16'h0040);
      cyc(4);
      rdc("ana", OFS_ANA, 16'h0000);
      wr(OFS_AMASK, 16'h0040);
      an.temp_conv <= 1'b1;
      an.temp_main <= 1'b1;
      cyc(6);
      chk("oen", 16'h0, {15'h0, foen});
      an.temp_conv <= 1'b0;
      cyc(4);
      wr(OFS_ANA, 16'h0020);
      cyc(4);
      chk("oen", 16'h1, {15'h0, foen});
      an.temp_main <= 1'b0;
      cyc(4);
      wr(OFS_ANA, 16'h0040);
      wr(OFS_AMASK, 16'h0000);
   endtask
   task automatic t_supply();
      an.ref_input_node <= 1'b1;
      cyc(6);
      rdc("ana", OFS_ANA, 16'h0000);
      wr(OFS_CFG_B, 16'h0001);
      cyc(6);
      rdc("ana", OFS_ANA, 16'h0000);
      wr(OFS_CONV, 16'h0001);
      wr(OFS_AMASK, 16'h07FF);
      cyc(6);
      chk("en", 16'h11, {11'h0, rbuf, cmp});
      rdc("ana", OFS_ANA, 16'h8100);
      an.ref_input_node <= 1'b0;
      cyc(4);
      wr(OFS_ANA, 16'h0100);
      wr(OFS_AMASK, 16'h0000);
   endtask
   task automatic t_dig();
      wr(OFS_DMASK, 16'h3FFF);
      dg.sclk_count <= 1'b1;
      cyc(3);
      chk("oen", 16'h0, {15'h0, foen});
      wr(OFS_CFG_A, 16'h0008);
      cyc(3);
      chk("oen", 16'h1, {15'h0, foen});
      rdc("stat", OFS_STAT, 16'h0001);
      dg.sclk_count <= 1'b0;
      wr(OFS_DIG, 16'h0400);
      dg.slew_busy <= 1'b1;
      cyc(3);
      rdc("stat", OFS_STAT, 16'h0000);
      dg.slew_busy <= 1'b0;
      other <= 1'b1;
      cyc(3);
      rdc("unmap", 4'hF, 16'h8000);
      other <= 1'b0;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      t_reset();
      t_temp();
      t_supply();
      t_dig();
      stop_test();
   end
endmodule
